// *** rtl/iefc_map.vh ***
// register map, field positions, reset values and fixed numbers of the
// interrupt enable and flag block; included by the block's control module.
`ifndef IEFC_MAP_VH
`define IEFC_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets on the axi4-lite slave
// ----------------------------------------------------------------------
`define IEFC_OFF_CORE_CTRL      8'h00
`define IEFC_OFF_PERIPH_EN      8'h04
`define IEFC_OFF_TIMER0_COUNT   8'h08
`define IEFC_OFF_EDGE_CFG       8'h0C
`define IEFC_OFF_CHANGE_EN      8'h10
`define IEFC_OFF_CHANGE_STAT    8'h14
`define IEFC_OFF_IRQ_STAT       8'h18
`define IEFC_OFF_IRQ_MASK       8'h1C
`define IEFC_OFF_PERIPH_FLAGS   8'h20

// ----------------------------------------------------------------------
// core interrupt control fields
// ----------------------------------------------------------------------
`define IEFC_GEN_BIT            7
`define IEFC_PGEN_BIT           6
`define IEFC_T0EN_BIT           5
`define IEFC_EXTIE_BIT          4
`define IEFC_CHGIE_BIT          3
`define IEFC_T0FL_BIT           2
`define IEFC_EXTIF_BIT          1
`define IEFC_CHGIF_BIT          0

// ----------------------------------------------------------------------
// sticky event status fields (status and mask share this layout)
// ----------------------------------------------------------------------
`define IEFC_EV_TIMER0          0
`define IEFC_EV_EXT_PIN         1
`define IEFC_EV_CHANGE          2
`define IEFC_EV_TAKEN           3
`define IEFC_EV_WIDTH           4

// ----------------------------------------------------------------------
// reset values and fixed numbers
// ----------------------------------------------------------------------
`define IEFC_RST_BYTE           8'h00
`define IEFC_RST_EV             4'h0
`define IEFC_IRQ_VECTOR         13'h0004
`define IEFC_TIMER0_TOP         8'hFF
`define IEFC_RESP_OKAY          2'h0
`define IEFC_RESP_SLVERR        2'h2

`endif

// *** rtl/iefc_sync.v ***
// two-stage synchroniser for a group of asynchronous pin levels.
// assumes the pins are quiet levels; the ce input freezes both stages.
`timescale 1ns/1ps
`default_nettype none

module iefc_sync #(
   parameter WIDTH = 1
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   // ------------------------------------------------------------------
   // stages
   // ------------------------------------------------------------------
   reg [WIDTH-1:0] meta; // first stage, read only by the second
   reg [WIDTH-1:0] stable; // second stage, safe to use

   // shift the pins through both stages
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= {WIDTH{1'b0}};
         stable <= {WIDTH{1'b0}};
      end else if (i_ce) begin
         meta <= i_async;
         stable <= meta;
      end
   end

   assign o_sync = stable;

endmodule

`default_nettype wire

// *** rtl/iefc_ctrl.v ***
// interrupt enable and flag control for a small processor core: core
// control register, first peripheral enable register, timer0 count,
// external edge pin and pin-change detection, and the core request.
// assumes an axi4-lite master on i_clk, peripheral flags as same-clock
// levels, and a core that pulses i_irq_taken / i_irq_return.
`timescale 1ns/1ps
`default_nettype none
`include "iefc_map.vh"

// Notes on behaviour
// - global enable gates every request to core
// - peripheral group enable gates all peripheral sources
// - timer0 and external flags set regardless of any enable bit
// - timer0 overflow enable masks timer0 flag
// - external pin enable masks external pin flag
// - pin change needs per-pin enables too
// - timer0 rollover sets flag; software clears it
// - timer0 count keeps its value through reset
// - external flag stays set until software clears
// - change flag shows any enabled pin changed
// - serial transmit and receive enables unmask
// - bus collision and sync port enables unmask
// - capture/compare two and one enables unmask
// - timer2 and timer1 enables unmask
// - taking interrupt clears global enable, vectors
// - edge select picks rising or falling edge
module iefc_ctrl #(
   parameter ADDR_W = 8,
   parameter CHG_PINS = 8
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // axi4-lite slave
   input wire [ADDR_W-1:0] i_awaddr,
   input wire [2:0] i_awprot,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [ADDR_W-1:0] i_araddr,
   input wire [2:0] i_arprot,
   input wire i_arvalid,
   output wire o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   // pins and peripherals
   input wire i_ext_pin,
   input wire [CHG_PINS-1:0] i_change_pins,
   input wire [7:0] i_periph_flags,
   input wire i_timer0_inc,
   // processor core
   input wire i_irq_taken,
   input wire i_irq_return,
   output reg o_core_irq,
   output reg o_push_ret,
   output reg [12:0] o_vector,
   // system interrupt
   output reg o_irq
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // true when an address selects the register at a given offset
   function hit;
      input [ADDR_W-1:0] addr;
      input [7:0] off;
      begin
         hit = (addr[7:2] == off[7:2]);
      end
   endfunction

   // byte-lane zero merged into an 8-bit register under its strobe
   function [7:0] lane0;
      input [7:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         lane0 = strb[0] ? data[7:0] : old;
      end
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   reg [7:0] ctrl_en; // enable bits 7..3 of the core control register
   reg t0_flag; // timer0 overflow flag
   reg ext_flag; // external pin flag
   reg [7:0] pen1; // first peripheral enable register
   reg [7:0] timer0_count; // timer0 counter, no reset
   reg edge_sel; // 1 rising, 0 falling
   reg [CHG_PINS-1:0] chg_en; // per-pin change enables
   reg [CHG_PINS-1:0] chg_pend; // per-pin change seen
   reg [`IEFC_EV_WIDTH-1:0] ev_stat; // sticky event status
   reg [`IEFC_EV_WIDTH-1:0] ev_mask; // event mask
   reg ext_prev; // last synced external level
   reg [CHG_PINS-1:0] chg_prev; // last synced change pins
   reg aw_full; // write address held
   reg w_full; // write data held
   reg [ADDR_W-1:0] aw_addr; // held write address
   reg [31:0] w_data; // held write data
   reg [3:0] w_strb; // held strobes

   wire ext_sync; // external pin after synchroniser
   wire [CHG_PINS-1:0] chg_sync; // change pins after synchroniser
   wire chg_flag; // pin change flag, derived
   wire do_wr; // register write happens this edge
   wire do_rd; // read address taken this edge
   wire ext_edge; // valid external edge
   wire [CHG_PINS-1:0] chg_edge; // enabled pin toggled
   wire t0_roll; // timer0 rolls over
   wire taken; // core takes an interrupt
   wire wr_ctrl, wr_pen1, wr_t0, wr_edge, wr_chen, wr_chst, wr_evst, wr_evmk;
   wire any_mapped_wr; // write hits a register
   wire [7:0] wb; // write byte
   wire next_core_irq; // request to the core
   wire [`IEFC_EV_WIDTH-1:0] ev_set; // events this cycle

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   iefc_sync #(
      .WIDTH(CHG_PINS + 1)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_async({i_ext_pin, i_change_pins}),
      .o_sync({ext_sync, chg_sync})
   );

   // ------------------------------------------------------------------
   // event detection
   // ------------------------------------------------------------------
   assign ext_edge = edge_sel ? (ext_sync & ~ext_prev) : (~ext_sync & ext_prev);
   assign chg_edge = (chg_sync ^ chg_prev) & chg_en;
   assign chg_flag = |chg_pend;
   assign t0_roll = i_timer0_inc & (timer0_count == `IEFC_TIMER0_TOP) & ~wr_t0;
   assign taken = i_irq_taken & ctrl_en[`IEFC_GEN_BIT];

   // remember previous synced levels for edge detection
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_prev <= 1'b0;
         chg_prev <= {CHG_PINS{1'b0}};
      end else if (i_ce) begin
         ext_prev <= ext_sync;
         chg_prev <= chg_sync;
      end
   end

   // ------------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------------
   assign o_awready = ~aw_full & ~o_bvalid & i_ce;
   assign o_wready = ~w_full & ~o_bvalid & i_ce;
   assign do_wr = aw_full & w_full & ~o_bvalid & i_ce;
   assign wb = w_data[7:0];
   assign wr_ctrl = do_wr & hit(aw_addr, `IEFC_OFF_CORE_CTRL);
   assign wr_pen1 = do_wr & hit(aw_addr, `IEFC_OFF_PERIPH_EN);
   assign wr_t0 = do_wr & hit(aw_addr, `IEFC_OFF_TIMER0_COUNT) & w_strb[0];
   assign wr_edge = do_wr & hit(aw_addr, `IEFC_OFF_EDGE_CFG);
   assign wr_chen = do_wr & hit(aw_addr, `IEFC_OFF_CHANGE_EN);
   assign wr_chst = do_wr & hit(aw_addr, `IEFC_OFF_CHANGE_STAT) & w_strb[0];
   assign wr_evst = do_wr & hit(aw_addr, `IEFC_OFF_IRQ_STAT) & w_strb[0];
   assign wr_evmk = do_wr & hit(aw_addr, `IEFC_OFF_IRQ_MASK);
   assign any_mapped_wr = hit(aw_addr, `IEFC_OFF_CORE_CTRL) | hit(aw_addr, `IEFC_OFF_PERIPH_EN)
      | hit(aw_addr, `IEFC_OFF_TIMER0_COUNT) | hit(aw_addr, `IEFC_OFF_EDGE_CFG)
      | hit(aw_addr, `IEFC_OFF_CHANGE_EN) | hit(aw_addr, `IEFC_OFF_CHANGE_STAT)
      | hit(aw_addr, `IEFC_OFF_IRQ_STAT) | hit(aw_addr, `IEFC_OFF_IRQ_MASK);

   // hold address and data in either order, answer once both are held
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= `IEFC_RESP_OKAY;
      end else if (i_ce) begin
         if (i_awvalid & o_awready) begin
            aw_full <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid & o_wready) begin
            w_full <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (do_wr) begin
            // write performed, release holders and answer
            aw_full <= 1'b0;
            w_full <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= any_mapped_wr ? `IEFC_RESP_OKAY : `IEFC_RESP_SLVERR;
         end else if (o_bvalid & i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // core control and peripheral enable registers
   // ------------------------------------------------------------------
   // enables and core flags; hardware sets win over software clears
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_en <= `IEFC_RST_BYTE;
         t0_flag <= 1'b0;
         ext_flag <= 1'b0;
         pen1 <= `IEFC_RST_BYTE;
         edge_sel <= 1'b0;
         chg_en <= {CHG_PINS{1'b0}};
      end else if (i_ce) begin
         if (wr_ctrl & w_strb[0]) begin
            ctrl_en <= {wb[7:3], 3'b000};
         end
         // core takes the interrupt: drop global enable
         if (taken) begin
            ctrl_en[`IEFC_GEN_BIT] <= 1'b0;
         end else if (i_irq_return) begin
            // return from service sets global enable again
            ctrl_en[`IEFC_GEN_BIT] <= 1'b1;
         end
         // flags set with no regard to enables
         t0_flag <= t0_roll | ((wr_ctrl & w_strb[0]) ? wb[`IEFC_T0FL_BIT] : t0_flag);
         ext_flag <= ext_edge | ((wr_ctrl & w_strb[0]) ? wb[`IEFC_EXTIF_BIT] : ext_flag);
         if (wr_pen1) begin
            pen1 <= lane0(pen1, w_data, w_strb);
         end
         if (wr_edge & w_strb[0]) begin
            edge_sel <= wb[0];
         end
         if (wr_chen & w_strb[0]) begin
            chg_en <= wb[CHG_PINS-1:0];
         end
      end
   end

   // per-pin change seen, cleared by writing one; a new change wins
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         chg_pend <= {CHG_PINS{1'b0}};
      end else if (i_ce) begin
         chg_pend <= chg_edge | (chg_pend & ~(wr_chst ? wb[CHG_PINS-1:0] : {CHG_PINS{1'b0}}));
      end
   end

   // ------------------------------------------------------------------
   // timer0 count
   // ------------------------------------------------------------------
   // kept through reset on purpose; software loads it before use
   always @(posedge i_clk) begin
      if (i_ce) begin
         if (wr_t0) begin
            timer0_count <= wb;
         end else if (i_timer0_inc) begin
            timer0_count <= timer0_count + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // core request and vectoring
   // ------------------------------------------------------------------
   assign next_core_irq = ctrl_en[`IEFC_GEN_BIT] & ~taken & (
      (ctrl_en[`IEFC_T0EN_BIT] & t0_flag)
      | (ctrl_en[`IEFC_EXTIE_BIT] & ext_flag)
      | (ctrl_en[`IEFC_CHGIE_BIT] & chg_flag)
      | (ctrl_en[`IEFC_PGEN_BIT] & (|(pen1 & i_periph_flags))));

   // registered request, return push pulse and vector
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_core_irq <= 1'b0;
         o_push_ret <= 1'b0;
         o_vector <= 13'h0000;
      end else if (i_ce) begin
         o_core_irq <= next_core_irq;
         o_push_ret <= taken;
         if (taken) begin
            o_vector <= `IEFC_IRQ_VECTOR;
         end
      end
   end

   // ------------------------------------------------------------------
   // system interrupt status and mask
   // ------------------------------------------------------------------
   assign ev_set = {taken, |chg_edge, ext_edge, t0_roll};

   // sticky status, write one to clear, set wins
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ev_stat <= `IEFC_RST_EV;
         ev_mask <= `IEFC_RST_EV;
         o_irq <= 1'b0;
      end else if (i_ce) begin
         ev_stat <= ev_set | (ev_stat & ~(wr_evst ? wb[`IEFC_EV_WIDTH-1:0] : `IEFC_RST_EV));
         if (wr_evmk & w_strb[0]) begin
            ev_mask <= wb[`IEFC_EV_WIDTH-1:0];
         end
         o_irq <= |(ev_stat & ev_mask);
      end
   end

   // ------------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------------
   assign o_arready = ~o_rvalid & i_ce;
   assign do_rd = i_arvalid & o_arready;

   // read data registered one cycle after the address is taken
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= `IEFC_RESP_OKAY;
      end else if (i_ce) begin
         if (do_rd) begin
            o_rvalid <= 1'b1;
            o_rresp <= `IEFC_RESP_OKAY;
            o_rdata <= 32'h00000000;
            if (hit(i_araddr, `IEFC_OFF_CORE_CTRL)) begin
               o_rdata[7:0] <= {ctrl_en[7:3], t0_flag, ext_flag, chg_flag};
            end else if (hit(i_araddr, `IEFC_OFF_PERIPH_EN)) begin
               o_rdata[7:0] <= pen1;
            end else if (hit(i_araddr, `IEFC_OFF_TIMER0_COUNT)) begin
               o_rdata[7:0] <= timer0_count;
            end else if (hit(i_araddr, `IEFC_OFF_EDGE_CFG)) begin
               o_rdata[0] <= edge_sel;
            end else if (hit(i_araddr, `IEFC_OFF_CHANGE_EN)) begin
               o_rdata[CHG_PINS-1:0] <= chg_en;
            end else if (hit(i_araddr, `IEFC_OFF_CHANGE_STAT)) begin
               o_rdata[CHG_PINS-1:0] <= chg_pend;
            end else if (hit(i_araddr, `IEFC_OFF_IRQ_STAT)) begin
               o_rdata[`IEFC_EV_WIDTH-1:0] <= ev_stat;
            end else if (hit(i_araddr, `IEFC_OFF_IRQ_MASK)) begin
               o_rdata[`IEFC_EV_WIDTH-1:0] <= ev_mask;
            end else if (hit(i_araddr, `IEFC_OFF_PERIPH_FLAGS)) begin
               o_rdata[7:0] <= i_periph_flags;
            end else begin
               // unmapped: zero data, slave error
               o_rresp <= `IEFC_RESP_SLVERR;
            end
         end else if (o_rvalid & i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** tb/iefc_ctrl_assertions.sv ***
// checker for the interrupt enable and flag block, bound to iefc_ctrl.
// assumes it sees only the block's ports on one clock and reset.
`timescale 1ns/1ps
`default_nettype none
module iefc_ctrl_chk #(
   parameter ADDR_W = 8,
   parameter CHG_PINS = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_irq_taken,
   input wire logic o_core_irq,
   input wire logic o_push_ret,
   input wire logic [12:0] o_vector
);
   // ----------------------------------------------------------------
   // core side
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_vector_load: assert property ($rose(o_push_ret) |-> o_vector == 13'h0004)
      else $error("vector not loaded on taken interrupt");
   chk_push_cause: assert property (o_push_ret |-> $past(i_irq_taken))
      else $error("return push without a taken interrupt");
   chk_push_pulse: assert property (o_push_ret |=> !o_push_ret)
      else $error("return push longer than one cycle");
   chk_req_drop: assert property (o_push_ret |=> !o_core_irq)
      else $error("core request still high after taken");
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   chk_write_resp: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
      else $error("write response missing");
   chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before ready");
   chk_read_lat: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data late");
   chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
      else $error("read data changed before ready");
   chk_ar_busy: assert property (o_rvalid |-> !o_arready)
      else $error("read address taken while data pending");
   chk_unmapped_rd: assert property (i_arvalid && o_arready && i_araddr == 8'h40 |=> o_rresp == 2'h2 && o_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule
bind iefc_ctrl iefc_ctrl_chk #(.ADDR_W(ADDR_W), .CHG_PINS(CHG_PINS)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .i_irq_taken(i_irq_taken),
   .o_core_irq(o_core_irq), .o_push_ret(o_push_ret), .o_vector(o_vector));
`default_nettype wire

// *** tb/iefc_core_model.sv ***
// model of the core sequencer: takes a request, promptly or after 3
// cycles, and signals return from service when the bench asks.
`timescale 1ns/1ps
`default_nettype none
module iefc_core_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_core_irq,
   input wire logic i_take_en,
   input wire logic i_slow,
   input wire logic i_ret_req,
   output var logic o_irq_taken,
   output var logic o_irq_return
);
   logic [1:0] wait_cnt; // cycles the request has waited
   // one-cycle take and return pulses
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_taken <= 1'b0;
         o_irq_return <= 1'b0;
         wait_cnt <= 2'h0;
      end else begin
         o_irq_taken <= 1'b0;
         o_irq_return <= i_ret_req;
         if (i_take_en && i_core_irq && !o_irq_taken) begin
            // slow mode lets the request stand a few cycles
            if (!i_slow || wait_cnt == 2'h3) begin
               o_irq_taken <= 1'b1;
               wait_cnt <= 2'h0;
            end else begin
               wait_cnt <= wait_cnt + 2'h1;
            end
         end else begin
            wait_cnt <= 2'h0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/interrupt_enable_and_flag_control_tb.sv ***
// self-checking bench for iefc_ctrl: table of enable and flag cases,
// then timer, edge pin, change pins, taken, unmapped and reset cases.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_and_flag_control_tb;
   logic i_clk = 0, i_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic ext_pin = 0, t0_inc = 0, take_en = 0, slow = 0, ret_req = 0;
   logic [7:0] awaddr = 0, araddr = 0, pflags = 0, chg = 0;
   logic [31:0] wdata = 0, rd;
   logic [1:0] resp;
   wire logic awready, wready, bvalid, arready, rvalid, core_irq, push_ret, irq, taken, ret;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [12:0] vector;
   int failures = 0, cmp_count = 0, i;
   logic [24:0] rows [6]; // control, enables, flags, expected request
   logic [2:0] erow [4]; // edge select, pin level, expected flag
   initial forever #5 i_clk = ~i_clk;
   iefc_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_awaddr(awaddr), .i_awprot(3'h0),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arprot(3'h0), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(rready), .i_ext_pin(ext_pin), .i_change_pins(chg),
      .i_periph_flags(pflags), .i_timer0_inc(t0_inc), .i_irq_taken(taken), .i_irq_return(ret),
      .o_core_irq(core_irq), .o_push_ret(push_ret), .o_vector(vector), .o_irq(irq));
   iefc_core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_core_irq(core_irq), .i_take_en(take_en),
      .i_slow(slow), .i_ret_req(ret_req), .o_irq_taken(taken), .o_irq_return(ret));
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // write: both channels offered together, ready for response raised late
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic got;
      got = 0;
      @(posedge i_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge i_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (n == 3) bready <= 1;
         if (bvalid && bready) begin
            got = 1;
            bready <= 0;
            resp = bresp;
         end
      end
      if (!got) begin
         failures++;
         tally_and_finish;
      end
   endtask
   task automatic bus_rd(input logic [7:0] a);
      int n;
      logic got;
      got = 0;
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge i_clk);
         if (arready) arvalid <= 0;
         if (n == 3) rready <= 1;
         if (rvalid && rready) begin
            got = 1;
            rready <= 0;
            rd = rdata;
            resp = rresp;
         end
      end
      if (!got) begin
         failures++;
         tally_and_finish;
      end
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus_rd(a);
      chk(nm, rd, e);
   endtask
   // one enable and flag case: request level and control readback
   task automatic run_case(input logic [24:0] r);
      pflags <= r[8:1];
      bus_wr(8'h04, {24'h0, r[16:9]});
      bus_wr(8'h00, {24'h0, r[24:17]});
      tk(3);
      chk("core_irq", {31'h0, core_irq}, {31'h0, r[0]});
      rd_chk("ctrl", 8'h00, {24'h0, r[24:17]});
      bus_wr(8'h00, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rows = '{{8'hA4, 16'h0, 1'b1}, {8'h24, 16'h0, 1'b0}, {8'h84, 16'h0, 1'b0}, {8'h92, 16'h0, 1'b1},
         {8'h80, 16'hFFFF, 1'b0}, {8'hC0, 16'hFF00, 1'b0}};
      erow = '{3'b111, 3'b100, 3'b010, 3'b001};
      tk(5);
      i_rst <= 0;
      for (i = 0; i < 6; i++) run_case(rows[i]);
      for (i = 0; i < 16; i++) run_case({8'hC0, 8'h1 << i[3:1], (8'h1 << i[3:1]) ^ {8{i[0]}}, !i[0]});
      // timer0 rollover, sticky status, mask and clear
      bus_wr(8'h08, 32'hFE);
      t0_inc <= 1;
      tk(2);
      t0_inc <= 0;
      rd_chk("count", 8'h08, 32'h0);
      rd_chk("t0_flag", 8'h00, 32'h04);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      bus_wr(8'h1C, 32'h1);
      tk(2);
      chk("irq", {31'h0, irq}, 32'h1);
      bus_wr(8'h18, 32'h1);
      tk(2);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      bus_wr(8'h00, 32'h0);
      rd_chk("t0_clr", 8'h00, 32'h0);
      // external pin on both edge selections
      for (i = 0; i < 4; i++) begin
         bus_wr(8'h0C, {31'h0, erow[i][2]});
         ext_pin <= erow[i][1];
         tk(5);
         rd_chk("ext_flag", 8'h00, {30'h0, erow[i][0], 1'b0});
         bus_wr(8'h00, 32'h0);
      end
      // change pins: only enabled pins count
      bus_wr(8'h10, 32'h01);
      chg <= 8'h02;
      tk(5);
      rd_chk("chg_off", 8'h00, 32'h0);
      chg <= 8'h03;
      tk(5);
      rd_chk("chg_on", 8'h00, 32'h1);
      bus_wr(8'h00, 32'h88);
      tk(3);
      chk("chg_irq", {31'h0, core_irq}, 32'h1);
      // core takes the request after a stall
      slow <= 1;
      take_en <= 1;
      for (i = 0; i < 20 && push_ret !== 1'b1; i++) @(posedge i_clk);
      take_en <= 0;
      if (i == 20) begin
         failures++;
         tally_and_finish;
      end
      chk("vector", {19'h0, vector}, 32'h0004);
      tk(2);
      chk("irq_off", {31'h0, core_irq}, 32'h0);
      rd_chk("gie_clr", 8'h00, 32'h09);
      ret_req <= 1;
      tk(1);
      ret_req <= 0;
      tk(3);
      rd_chk("gie_set", 8'h00, 32'h89);
      bus_wr(8'h14, 32'hFF);
      rd_chk("chg_clr", 8'h00, 32'h88);
      bus_wr(8'h00, 32'h0);
      // unmapped place refused
      bus_rd(8'h40);
      chk("rresp", {30'h0, resp}, 32'h2);
      chk("rdata", rd, 32'h0);
      bus_wr(8'h40, 32'hFF);
      chk("bresp", {30'h0, resp}, 32'h2);
      // reset in mid-run: count kept, enables cleared
      bus_wr(8'h04, 32'hFF);
      bus_wr(8'h08, 32'h5A);
      bus_wr(8'h00, 32'hF8);
      i_rst <= 1;
      tk(2);
      i_rst <= 0;
      chk("rst_irq", {31'h0, core_irq}, 32'h0);
      rd_chk("kept", 8'h08, 32'h5A);
      rd_chk("rst_ctrl", 8'h00, 32'h0);
      rd_chk("rst_pie", 8'h04, 32'h0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
